// *** fidsl_cycle.sv ***
// One parallel bus cycle (read or write) with fixed setup, strobe and hold.
// Assumes pins registered by the caller's flops; the flash is asynchronous.
`timescale 1ns/1ns
module fidsl_cycle (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic is_write,
	input wire logic [fidsl_pkg::DATA_W-1:0] din,
	output logic strobe_n,
	output logic oe_n,
	output logic sample,
	output logic done
);
	typedef enum logic [1:0] {C_IDLE = 2'b00, C_SET = 2'b01, C_PUL = 2'b11, C_HLD = 2'b10} fidsl_c_e;
	typedef struct packed {
		fidsl_c_e st;
		logic wr;
		logic [fidsl_pkg::CNT_W-1:0] cnt;
	} fidsl_cst_s;
	fidsl_cst_s q, d;

	always_comb begin
		d = q;
		sample = 1'b0;
		done = 1'b0;
		case (q.st)
			C_IDLE: begin
				if (start) begin
					d.st = C_SET;
					d.wr = is_write;
					d.cnt = fidsl_pkg::CNT_W'(fidsl_pkg::SETUP_CYC - 1);
				end
			end
			C_SET: begin
				if (q.cnt == '0) begin
					d.st = C_PUL;
					d.cnt = fidsl_pkg::CNT_W'(fidsl_pkg::PULSE_CYC - 1);
				end else
					d.cnt = q.cnt - 1'b1;
			end
			C_PUL: begin
				if (q.cnt == '0) begin
					d.st = C_HLD;
					d.cnt = fidsl_pkg::CNT_W'(fidsl_pkg::HOLD_CYC - 1);
					sample = !q.wr;
				end else
					d.cnt = q.cnt - 1'b1;
			end
			C_HLD: begin
				if (q.cnt == '0) begin
					d.st = C_IDLE;
					done = 1'b1;
				end else
					d.cnt = q.cnt - 1'b1;
			end
			default: d.st = C_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	// Write: strobe low with output enable high; read: both low
	assign strobe_n = (q.st != C_PUL);
	assign oe_n = q.wr | (q.st != C_PUL);
	wire logic unused_din = ^din;
endmodule

// *** fidsl_flash_model.sv ***
// Behavioural byte-wide flash for the host controller bench.
// Assumes pins registered on clk; released data lines flip every cycle.
`timescale 1ns/1ns
module fidsl_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'hC3 // Arbitrary value
) (
	input wire logic clk,
	input wire fidsl_pkg::fidsl_pins_s pins,
	input wire logic supply_low,
	output logic [7:0] data_out
);
	logic [7:0] flags = 8'h00;
	int prog_cnt = 0;
	int erase_cnt = 0;
	int step = 0;
	logic id_mode = 1'b0;
	logic we_q = 1'b1;
	logic fell = 1'b0;
	logic ok_q = 1'b0;
	logic [20:0] lat_a = '0;
	logic [7:0] dat_q = '0;
	logic [7:0] val;
	logic hit;
	initial data_out = 8'h00;
	always_comb begin
		hit = flags[lat_a[20:18]] && !pins.reset_hv;
		if (!pins.id_line_hv && !id_mode)
			val = 8'hFF;
		else if (pins.addr[1:0] == 2'h0)
			val = MAKER_CODE;
		else if (pins.addr[1:0] == 2'h1)
			val = PART_CODE;
		else
			val = flags[pins.addr[20:18]] ? 8'h01 : 8'h00;
	end
	// Any write that breaks a sequence restarts it at step 0; only an F0 write, a reset or low supply leaves identification mode
	task automatic take(input logic [20:0] a, input logic [7:0] d);
		logic ua;
		logic ub;
		ua = a[10:0] == 11'h555;
		ub = a[10:0] == 11'h2AA;
		step <= 0;
		if (d == 8'hF0)
			id_mode <= 1'b0;
		else if (step == 0 && ua && d == 8'hAA)
			step <= 1;
		else if (step == 1 && ub && d == 8'h55)
			step <= 2;
		else if (step == 2 && ua && d == 8'h90)
			id_mode <= 1'b1;
		else if (step == 2 && ua && d == 8'hA0)
			step <= 3;
		else if (step == 2 && ua && d == 8'h80)
			step <= 4;
		else if (step == 3 && !hit)
			prog_cnt <= prog_cnt + 1;
		else if (step == 4 && ua && d == 8'hAA)
			step <= 5;
		else if (step == 5 && ub && d == 8'h55)
			step <= 6;
		else if (step == 6 && d == 8'h30 && !hit)
			erase_cnt <= erase_cnt + 1;
	endtask
	always @(posedge clk) begin
		data_out <= (!pins.ce_n && !pins.oe_n && pins.reset_n) ? val : ~data_out;
		we_q <= pins.we_n;
		if (!pins.we_n) begin
			dat_q <= pins.dout;
			ok_q <= !pins.ce_n && pins.oe_n;
		end
		if (!pins.reset_n || supply_low) begin
			step <= 0;
			id_mode <= 1'b0;
			fell <= 1'b0;
		end else if (we_q && !pins.we_n) begin
			lat_a <= pins.addr;
			fell <= 1'b1;
		end else if (!we_q && pins.we_n && fell) begin
			fell <= 1'b0;
			if (ok_q)
				take(lat_a, dat_q);
		end
	end
endmodule

// *** fidsl_host.sv ***
// Host controller for identification, protection checks and unlocked
// program/erase on an asynchronous byte-wide flash.
// Assumes the pins are synchronous to REF_CLK and the elevated voltages are
// made by external switches steered by the *_HV outputs.
`timescale 1ns/1ns
module fidsl_host (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire fidsl_pkg::fidsl_req_s REQ,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic TEMP_UNPROTECT,
	input wire logic SUPPLY_LOW,
	output logic [fidsl_pkg::DATA_W-1:0] RESULT,
	output logic RESULT_VALID,
	output logic GROUP_PROTECTED,
	output fidsl_pkg::fidsl_pins_s PINS,
	input wire logic [fidsl_pkg::DATA_W-1:0] DATA_LINES_IN
);
	localparam logic [2:0] STEP_NONE = 3'h0;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SEQ = 3'b001,
		S_CYC = 3'b011,
		S_NEXT = 3'b010,
		S_DONE = 3'b110,
		S_RSTP = 3'b111
	} fidsl_st_e;

	typedef struct packed {
		fidsl_st_e st;
		fidsl_pkg::fidsl_req_s req;
		logic [2:0] step;
		logic [2:0] last;
		logic wr;
		fidsl_pkg::fidsl_pins_s pins;
		logic [fidsl_pkg::DATA_W-1:0] result;
		logic result_valid;
		logic [fidsl_pkg::CNT_W-1:0] cnt;
	} fidsl_state_s;
	fidsl_state_s q, d;

	logic cyc_start, cyc_strobe_n, cyc_oe_n, cyc_sample, cyc_done;

	fidsl_cycle u_cycle (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.start(cyc_start),
		.is_write(q.wr),
		.din(q.pins.dout),
		.strobe_n(cyc_strobe_n),
		.oe_n(cyc_oe_n),
		.sample(cyc_sample),
		.done(cyc_done)
	);

	// Address for an identification read: bit six low, bits one/zero pick code
	function automatic logic [fidsl_pkg::ADDR_W-1:0] id_addr(
		input fidsl_pkg::fidsl_sel_e sel,
		input logic [fidsl_pkg::ADDR_W-1:0] base
	);
		logic [fidsl_pkg::ADDR_W-1:0] a;
		a = base;
		a[fidsl_pkg::BIT_SIX] = 1'b0;
		a[fidsl_pkg::BIT_ONE] = (sel == fidsl_pkg::SEL_GROUP);
		a[fidsl_pkg::BIT_ZERO] = (sel == fidsl_pkg::SEL_PART);
		return a;
	endfunction

	// Bus cycle list per operation; step indexes the cycle within it
	function automatic void step_cycle(
		input fidsl_pkg::fidsl_req_s r,
		input logic [2:0] s,
		output logic wr,
		output logic [fidsl_pkg::ADDR_W-1:0] a,
		output logic [fidsl_pkg::DATA_W-1:0] dt
	);
		logic odd;
		odd = s[0];
		wr = 1'b1;
		a = odd ? fidsl_pkg::UNLOCK_ADDR_B : fidsl_pkg::UNLOCK_ADDR_A;
		dt = odd ? fidsl_pkg::UNLOCK_DATA_B : fidsl_pkg::UNLOCK_DATA_A;
		case (r.op)
			fidsl_pkg::OP_READ: begin
				wr = 1'b0;
				a = r.addr;
			end
			fidsl_pkg::OP_ID_HV, fidsl_pkg::OP_PROTECT_HV: begin
				wr = 1'b0;
				a = id_addr(r.sel, r.addr);
			end
			fidsl_pkg::OP_ID_CMD: begin
				if (s == 3'h2) begin
					a = fidsl_pkg::UNLOCK_ADDR_A;
					dt = fidsl_pkg::CMD_IDENT;
				end else if (s == 3'h3) begin
					wr = 1'b0;
					a = id_addr(r.sel, r.addr);
				end else if (s == 3'h4) begin
					a = r.addr;
					dt = fidsl_pkg::CMD_RESET;
				end
			end
			fidsl_pkg::OP_PROGRAM: begin
				if (s == 3'h2) begin
					a = fidsl_pkg::UNLOCK_ADDR_A;
					dt = fidsl_pkg::CMD_PROGRAM;
				end else if (s == 3'h3) begin
					a = r.addr;
					dt = r.data;
				end
			end
			fidsl_pkg::OP_ERASE: begin
				// Second unlock pair restarts at the first word, so parity flips here
				if (s == 3'h2) begin
					a = fidsl_pkg::UNLOCK_ADDR_A;
					dt = fidsl_pkg::CMD_ERASE;
				end else if (s == 3'h3) begin
					a = fidsl_pkg::UNLOCK_ADDR_A;
					dt = fidsl_pkg::UNLOCK_DATA_A;
				end else if (s == 3'h4) begin
					a = fidsl_pkg::UNLOCK_ADDR_B;
					dt = fidsl_pkg::UNLOCK_DATA_B;
				end else if (s == 3'h5) begin
					a = r.addr;
					dt = fidsl_pkg::CMD_SECTOR;
				end
			end
			default: begin
				a = r.addr;
				dt = fidsl_pkg::CMD_RESET;
			end
		endcase
	endfunction

	function automatic logic [2:0] last_step(input fidsl_pkg::fidsl_op_e op);
		case (op)
			fidsl_pkg::OP_ID_CMD: last_step = 3'h4;
			fidsl_pkg::OP_PROGRAM: last_step = 3'h3;
			fidsl_pkg::OP_ERASE: last_step = 3'h5;
			default: last_step = STEP_NONE;
		endcase
	endfunction

	always_comb begin
		logic wr;
		logic [fidsl_pkg::ADDR_W-1:0] a;
		logic [fidsl_pkg::DATA_W-1:0] dt;
		d = q;
		wr = 1'b0;
		a = '0;
		dt = '0;
		cyc_start = 1'b0;
		d.result_valid = 1'b0;
		step_cycle(q.req, q.step, wr, a, dt);
		// Write strobe shows only while the cycle pulse is low and OE is high
		d.pins.we_n = !q.wr | cyc_strobe_n;
		d.pins.ce_n = cyc_strobe_n;
		d.pins.oe_n = cyc_oe_n;
		d.pins.reset_hv = TEMP_UNPROTECT;
		case (q.st)
			S_IDLE: begin
				d.pins.id_line_hv = 1'b0;
				d.pins.dout_oe = 1'b0;
				if (REQ_VALID && !SUPPLY_LOW) begin
					d.req = REQ;
					d.step = STEP_NONE;
					d.last = last_step(REQ.op);
					d.st = (REQ.op == fidsl_pkg::OP_RESET) ? S_RSTP : S_SEQ;
					d.cnt = fidsl_pkg::CNT_W'(fidsl_pkg::PULSE_CYC);
				end
			end
			S_SEQ: begin
				d.wr = wr;
				d.pins.addr = a;
				d.pins.dout = dt;
				d.pins.dout_oe = wr;
				// Elevated voltage only with read-only ops: never alters stored flags
				d.pins.id_line_hv = (q.req.op == fidsl_pkg::OP_ID_HV) ||
					(q.req.op == fidsl_pkg::OP_PROTECT_HV);
				d.st = S_CYC;
			end
			S_CYC: begin
				cyc_start = (q.cnt == '0);
				d.cnt = '0;
				if (cyc_sample)
					d.result = DATA_LINES_IN;
				if (cyc_done)
					d.st = (q.step == q.last) ? S_DONE : S_NEXT;
			end
			S_NEXT: begin
				// Unlock pairs always lead program and erase writes
				d.step = q.step + 3'h1;
				d.cnt = '0;
				d.st = S_SEQ;
			end
			S_DONE: begin
				d.pins.dout_oe = 1'b0;
				d.pins.id_line_hv = 1'b0;
				d.result_valid = 1'b1;
				d.st = S_IDLE;
			end
			S_RSTP: begin
				// Hold the flash reset low long enough to abort its work
				d.pins.reset_n = 1'b0;
				if (q.cnt == '0) begin
					d.pins.reset_n = 1'b1;
					d.st = S_DONE;
				end else
					d.cnt = q.cnt - 1'b1;
			end
			default: d.st = S_IDLE;
		endcase
		if (q.st == S_SEQ)
			d.cnt = '0;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			q <= '0;
			q.pins.ce_n <= 1'b1;
			q.pins.oe_n <= 1'b1;
			q.pins.we_n <= 1'b1;
			q.pins.reset_n <= 1'b1;
		end else
			q <= d;
	end

	assign REQ_READY = (q.st == S_IDLE) && !SUPPLY_LOW;
	assign RESULT = q.result;
	assign RESULT_VALID = q.result_valid;
	assign GROUP_PROTECTED = q.result != fidsl_pkg::UNPROTECTED;
	assign PINS = q.pins;

	a_write_oe_high: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!q.pins.we_n |-> q.pins.oe_n && !q.pins.ce_n)
		else $error("write strobe with output enable low");
	a_hv_no_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		q.pins.id_line_hv |-> q.pins.we_n && !q.pins.dout_oe)
		else $error("write attempted with elevated identification voltage");
	a_id_bit_six: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		q.pins.id_line_hv |-> !q.pins.addr[fidsl_pkg::BIT_SIX])
		else $error("bit six high in identification");
	a_no_hv_cmd: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		q.req.op == fidsl_pkg::OP_ID_CMD && q.st == S_CYC |-> !q.pins.id_line_hv)
		else $error("elevated voltage in command identification");
	a_grp_addr: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		q.pins.id_line_hv && q.req.sel == fidsl_pkg::SEL_GROUP && q.st == S_CYC
		|-> q.pins.addr[fidsl_pkg::BIT_ONE] && !q.pins.addr[fidsl_pkg::BIT_ZERO])
		else $error("bad protection check address");
	a_unlock_first: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$rose(q.st == S_CYC) && q.step == STEP_NONE && q.wr
		|-> q.pins.dout == fidsl_pkg::UNLOCK_DATA_A)
		else $error("write sequence without unlock");
	a_reset_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$fell(q.pins.reset_n) |-> !q.pins.reset_n [*3])
		else $error("reset pulse too short");
	a_lockout_idle: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		SUPPLY_LOW && q.st == S_IDLE |=> q.st == S_IDLE)
		else $error("request taken under supply lockout");
	a_temp_unprot: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		TEMP_UNPROTECT |=> q.pins.reset_hv)
		else $error("reset elevated voltage not driven");
	a_temp_restore: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!TEMP_UNPROTECT |=> !q.pins.reset_hv)
		else $error("reset elevated voltage left on");
endmodule

// *** fidsl_pkg.sv ***
// Package for the flash identification and sector-group lock host controller.
// Assumes a byte-wide parallel flash with 21 address lines on the far side.
package fidsl_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;
	localparam int GROUP_W = 3;
	localparam int GROUP_LSB = 18;
	localparam int ID_LINE_BIT = 9;
	localparam int BIT_SIX = 6;
	localparam int BIT_ONE = 1;
	localparam int BIT_ZERO = 0;
	// Bus phase lengths in ns at a 125 MHz reference
	localparam int CLK_NS = 8;
	localparam int SETUP_NS = 40;
	localparam int PULSE_NS = 80;
	localparam int HOLD_NS = 40;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 8;
	// Unlock words, command words and the unprotected flag value
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 21'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 21'h0002AA;
	localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 8'hAA;
	localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 8'h55;
	localparam logic [DATA_W-1:0] CMD_IDENT = 8'h90;
	localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
	localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'hA0;
	localparam logic [DATA_W-1:0] CMD_ERASE = 8'h80;
	localparam logic [DATA_W-1:0] CMD_SECTOR = 8'h30;
	localparam logic [DATA_W-1:0] UNPROTECTED = 8'h00;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_ID_HV = 3'h1,
		OP_ID_CMD = 3'h2,
		OP_PROTECT_HV = 3'h3,
		OP_PROGRAM = 3'h4,
		OP_ERASE = 3'h5,
		OP_RESET = 3'h6
	} fidsl_op_e;

	typedef enum logic [1:0] {
		SEL_MAKER = 2'h0,
		SEL_PART = 2'h1,
		SEL_GROUP = 2'h2
	} fidsl_sel_e;

	typedef struct packed {
		fidsl_op_e op;
		fidsl_sel_e sel;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fidsl_req_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic dout_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic id_line_hv;
		logic reset_n;
		logic reset_hv;
	} fidsl_pins_s;
endpackage

// *** tb.sv ***
// Self-checking bench for the flash host controller.
// Assumes the behavioural flash model answers on the far side.
`timescale 1ns/1ns
module tb;
	localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
	localparam logic [7:0] PART = 8'hC3; // Arbitrary value
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	fidsl_pkg::fidsl_req_s req = '0;
	logic req_valid = 1'b0;
	logic temp_unprotect = 1'b0;
	logic supply_low = 1'b0;
	logic req_ready, result_valid, group_protected;
	logic [7:0] result, data_lines;
	fidsl_pkg::fidsl_pins_s pins;
	int error_cnt = 0;
	int total_checks = 0;
	always #4 ref_clk = ~ref_clk;
	fidsl_host dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .REQ(req), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .TEMP_UNPROTECT(temp_unprotect), .SUPPLY_LOW(supply_low),
		.RESULT(result), .RESULT_VALID(result_valid), .GROUP_PROTECTED(group_protected),
		.PINS(pins), .DATA_LINES_IN(data_lines));
	fidsl_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (.clk(ref_clk),
		.pins(pins), .supply_low(supply_low), .data_out(data_lines));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic run_op(input fidsl_pkg::fidsl_op_e op, input logic [20:0] a,
		input fidsl_pkg::fidsl_sel_e sel);
		int n;
		req.op = op;
		req.sel = sel;
		req.addr = a;
		req.data = 8'h3C;
		req_valid = 1'b1;
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		tick(1);
		req_valid = 1'b0;
		while (result_valid !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		if (result_valid !== 1'b1) begin
			check(result_valid, 1);
			complete_run();
		end
	endtask
	// Write strobe only with output enable high; bit six low during elevated-voltage identification reads
	always @(negedge ref_clk) begin
		if (rst_n && !pins.we_n && pins.oe_n !== 1'b1)
			check(pins.oe_n, 1);
		if (rst_n && pins.id_line_hv && !pins.oe_n)
			check(pins.addr[6], 0);
	end
	task automatic s_reset();
		check(pins.ce_n & pins.oe_n & pins.we_n & pins.reset_n, 1);
		check(pins.dout_oe | result_valid | pins.id_line_hv, 0);
		check(req_ready, 1);
	endtask
	task automatic s_ident();
		run_op(fidsl_pkg::OP_ID_HV, 21'h0, fidsl_pkg::SEL_MAKER);
		check(result, MAKER);
		run_op(fidsl_pkg::OP_ID_HV, 21'h0, fidsl_pkg::SEL_PART);
		check(result, PART);
		run_op(fidsl_pkg::OP_ID_CMD, 21'h0, fidsl_pkg::SEL_MAKER);
		check(result, MAKER);
		run_op(fidsl_pkg::OP_ID_CMD, 21'h0, fidsl_pkg::SEL_PART);
		check(result, PART);
		run_op(fidsl_pkg::OP_ID_CMD, 21'h1C0000, fidsl_pkg::SEL_GROUP);
		check(result, 8'h00);
		run_op(fidsl_pkg::OP_READ, 21'h000001, fidsl_pkg::SEL_MAKER);
		check(result, 8'hFF);
		run_op(fidsl_pkg::OP_RESET, 21'h0, fidsl_pkg::SEL_MAKER);
		check(pins.reset_n, 1);
	endtask
	task automatic s_protect();
		logic [7:0] e;
		flash_u.flags = 8'hA5;
		for (int g = 0; g < 8; g++) begin
			e = {7'h00, flash_u.flags[g]};
			run_op(fidsl_pkg::OP_PROTECT_HV, {g[2:0], 18'h0}, fidsl_pkg::SEL_GROUP);
			check(result, e);
			check(group_protected, e[0]);
		end
		run_op(fidsl_pkg::OP_ID_CMD, 21'h140000, fidsl_pkg::SEL_GROUP);
		check(result, 8'h01);
	endtask
	task automatic alter(input fidsl_pkg::fidsl_op_e op, input logic [2:0] g, input int d);
		int c;
		c = flash_u.prog_cnt + flash_u.erase_cnt;
		run_op(op, {g, 18'h00123}, fidsl_pkg::SEL_MAKER);
		check(flash_u.prog_cnt + flash_u.erase_cnt - c, d);
	endtask
	task automatic s_program();
		alter(fidsl_pkg::OP_PROGRAM, 3'h0, 0);
		alter(fidsl_pkg::OP_PROGRAM, 3'h1, 1);
		temp_unprotect = 1'b1;
		tick(2);
		alter(fidsl_pkg::OP_PROGRAM, 3'h0, 1);
		alter(fidsl_pkg::OP_ERASE, 3'h2, 1);
		temp_unprotect = 1'b0;
		tick(2);
		alter(fidsl_pkg::OP_ERASE, 3'h2, 0);
		alter(fidsl_pkg::OP_PROGRAM, 3'h7, 0);
		flash_u.flags = 8'h00;
		alter(fidsl_pkg::OP_PROGRAM, 3'h0, 1);
		alter(fidsl_pkg::OP_ERASE, 3'h7, 1);
	endtask
	task automatic s_supply();
		supply_low = 1'b1;
		tick(1);
		check(req_ready, 0);
		req_valid = 1'b1;
		repeat (6) begin
			tick(1);
			check(result_valid, 0);
		end
		req_valid = 1'b0;
		supply_low = 1'b0;
		tick(1);
		check(req_ready, 1);
	endtask
	initial begin
		tick(20);
		rst_n = 1'b1;
		s_reset();
		s_ident();
		s_protect();
		s_program();
		s_supply();
		complete_run();
	end
endmodule
